// ---- core/adc_output_code_justify.sv ----
// output code justifier: apb registers, formatter and serial word sender
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module adc_output_code_justify #(
   parameter int SER_DIV = acj_pkg::SER_BIT_CYC,
   parameter int BUF_DEPTH = 2
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [acj_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // converter results
   input wire logic convValid,
   input wire logic [acj_pkg::WORD_W-1:0] convData0,
   input wire logic [acj_pkg::WORD_W-1:0] convData1,
   input wire logic [1:0] satPos,
   input wire logic [1:0] satNeg,
   output logic convReady,
   // serial words
   output logic serData,
   output logic serFrame,
   output logic serChan,
   // analog controls
   output logic intRefEnable,
   output logic [7:0] refTrim,
   output logic [2:0] osrSetting
);
   import acj_pkg::*;

   initial begin
      if (SER_DIV < 1 || SER_DIV > 65535) begin
         $error("adc_output_code_justify: SER_DIV out of range");
      end
   end

   // ------------------------------------------------------------
   // configuration state
   // ------------------------------------------------------------
   logic [7:0] trim_q;
   logic [2:0] osr_q;
   logic extRef_q;
   logic intRef_q;
   acj_width_t width_q;
   logic [23:0] last0_q;
   logic [23:0] last1_q;

   // ------------------------------------------------------------
   // apb slave
   // ------------------------------------------------------------
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic hit;
   logic wrEn;
   logic busy;
   logic pend;
   logic [31:0] rdMux;

   always_comb begin
      hit = 1'b1;
      rdMux = 32'h0;
      case (paddr)
         OFF_CFG0: rdMux = {21'h0, osr_q, trim_q};
         OFF_CFG1: rdMux = {31'h0, extRef_q};
         OFF_STAT: rdMux = {22'h0, pend, busy, 6'h0, width_q};
         OFF_DATA0: rdMux = {8'h0, last0_q};
         OFF_DATA1: rdMux = {8'h0, last1_q};
         default: hit = 1'b0;
      endcase
   end

   assign wrEn = psel & penable & pready_q & pwrite & hit;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else begin
         pready_q <= psel & penable & ~pready_q;
         if (psel && penable && !pready_q) begin
            pslverr_q <= ~hit;
            prdata_q <= (pwrite || !hit) ? 32'h0 : rdMux;
         end else begin
            pslverr_q <= 1'b0;
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         trim_q <= TRIM_RST;
         osr_q <= OSR_RST;
      end else if (wrEn && paddr == OFF_CFG0) begin
         trim_q <= pwdata[TRIM_LSB +: 8];
         osr_q <= pwdata[OSR_LSB +: 3];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         extRef_q <= EXTREF_RST;
         intRef_q <= ~EXTREF_RST;
      end else if (wrEn && paddr == OFF_CFG1) begin
         extRef_q <= pwdata[EXTREF_BIT];
         intRef_q <= ~pwdata[EXTREF_BIT];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         width_q <= WIDTH_RST;
      end else if (wrEn && paddr == OFF_STAT) begin
         width_q <= acj_width_t'(pwdata[WIDTH_LSB +: 2]);
      end
   end

   assign intRefEnable = intRef_q;
   assign refTrim = trim_q;
   assign osrSetting = osr_q;

   // ------------------------------------------------------------
   // justify both channels with one ratio
   // ------------------------------------------------------------
   acj_pair_if fillBus ();
   acj_pair_if drainBus ();
   logic [23:0] rawCh [2];
   logic [23:0] justCh [2];

   assign rawCh[0] = convData0;
   assign rawCh[1] = convData1;

   for (genvar ch = 0; ch < 2; ch++) begin : gJust
      acj_justify uJust (
         .raw(rawCh[ch]),
         .satPos(satPos[ch]),
         .satNeg(satNeg[ch]),
         .osrSel(osr_q),
         .word(justCh[ch])
      );
   end

   assign fillBus.valid = convValid;
   assign fillBus.data0 = justCh[0];
   assign fillBus.data1 = justCh[1];
   assign convReady = fillBus.ready;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         last0_q <= 24'h0;
         last1_q <= 24'h0;
      end else if (convValid && fillBus.ready) begin
         last0_q <= justCh[0];
         last1_q <= justCh[1];
      end
   end

   acj_pair_buf #(
      .DEPTH(BUF_DEPTH)
   ) uBuf (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .fillPort(fillBus),
      .drainPort(drainBus),
      .notEmpty(pend)
   );

   // ------------------------------------------------------------
   // bit rate divider
   // ------------------------------------------------------------
   logic [15:0] div_q;
   logic bitEn_q;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         div_q <= 16'h0;
         bitEn_q <= 1'b0;
      end else if (div_q == 16'(SER_DIV - 1)) begin
         div_q <= 16'h0;
         bitEn_q <= 1'b1;
      end else begin
         div_q <= div_q + 16'h1;
         bitEn_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // serial word sender
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ACJ_IDLE = 2'b01,
      ACJ_SEND = 2'b10
   } acj_ser_t;

   acj_ser_t state_q;
   logic [31:0] sh_q;
   logic [5:0] left_q;
   logic half_q;
   logic serData_q;
   logic serFrame_q;
   logic serChan_q;
   logic [31:0] fmtWord;
   logic [5:0] fmtBits;
   logic [23:0] fmtSrc;

   assign fmtSrc = (state_q == ACJ_SEND) ? drainBus.data1 : drainBus.data0;

   always_comb begin
      case (width_q)
         ACJ_W16: begin
            fmtWord = {fmtSrc[23:8], 16'h0};
            fmtBits = 6'h10;
         end
         ACJ_W32Z: begin
            fmtWord = {fmtSrc, 8'h0};
            fmtBits = 6'h20;
         end
         ACJ_W32S: begin
            fmtWord = {{8{fmtSrc[23]}}, fmtSrc};
            fmtBits = 6'h20;
         end
         default: begin
            fmtWord = {fmtSrc, 8'h0};
            fmtBits = 6'h18;
         end
      endcase
   end

   assign drainBus.ready = (state_q == ACJ_SEND) & bitEn_q & (left_q == 6'h0) & half_q;
   assign busy = (state_q == ACJ_SEND);

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= ACJ_IDLE;
         sh_q <= 32'h0;
         left_q <= 6'h0;
         half_q <= 1'b0;
         serData_q <= 1'b0;
         serFrame_q <= 1'b0;
         serChan_q <= 1'b0;
      end else begin
         case (state_q)
            ACJ_IDLE: begin
               if (drainBus.valid) begin
                  sh_q <= fmtWord;
                  left_q <= fmtBits;
                  half_q <= 1'b0;
                  state_q <= ACJ_SEND;
               end
            end
            ACJ_SEND: begin
               if (bitEn_q) begin
                  if (left_q != 6'h0) begin
                     serData_q <= sh_q[31];
                     sh_q <= {sh_q[30:0], 1'b0};
                     left_q <= left_q - 6'h1;
                     serFrame_q <= 1'b1;
                     serChan_q <= half_q;
                  end else begin
                     serFrame_q <= 1'b0;
                     serData_q <= 1'b0;
                     if (!half_q) begin
                        sh_q <= fmtWord;
                        left_q <= fmtBits;
                        half_q <= 1'b1;
                     end else begin
                        state_q <= ACJ_IDLE;
                     end
                  end
               end
            end
            default: state_q <= ACJ_IDLE;
         endcase
      end
   end

   assign serData = serData_q;
   assign serFrame = serFrame_q;
   assign serChan = serChan_q;

endmodule // adc_output_code_justify

`default_nettype wire

// ---- core/acj_pkg.sv ----
// constants, types and register map of the output code justifier
`default_nettype none

package acj_pkg;

   // ------------------------------------------------------------
   // bus and register map
   // ------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_CFG0 = 8'h00;
   localparam logic [7:0] OFF_CFG1 = 8'h04;
   localparam logic [7:0] OFF_STAT = 8'h08;
   localparam logic [7:0] OFF_DATA0 = 8'h0c;
   localparam logic [7:0] OFF_DATA1 = 8'h10;

   // ------------------------------------------------------------
   // fields and reset values
   // ------------------------------------------------------------
   localparam int TRIM_LSB = 0;
   localparam logic [7:0] TRIM_RST = 8'h50;
   localparam int OSR_LSB = 8;
   localparam logic [2:0] OSR_RST = 3'h3;
   localparam int EXTREF_BIT = 0;
   localparam logic EXTREF_RST = 1'b0;
   localparam int WIDTH_LSB = 0;
   localparam int BUSY_BIT = 8;
   localparam int PEND_BIT = 9;

   // ------------------------------------------------------------
   // codes
   // ------------------------------------------------------------
   localparam int WORD_W = 24;
   localparam logic [23:0] POS_FULL = 24'h7fffff;
   localparam logic [23:0] NEG_FULL = 24'h800000;
   localparam logic [2:0] OSR_32 = 3'h0;
   localparam logic [2:0] OSR_64 = 3'h1;
   localparam logic [2:0] OSR_128 = 3'h2;
   localparam logic [23:0] MASK_32 = 24'hffff80;
   localparam logic [23:0] MASK_64 = 24'hfffff0;
   localparam logic [23:0] MASK_128 = 24'hfffffe;
   localparam logic [23:0] MASK_FULL = 24'hffffff;

   typedef enum logic [1:0] {
      ACJ_W16 = 2'h0,
      ACJ_W24 = 2'h1,
      ACJ_W32Z = 2'h2,
      ACJ_W32S = 2'h3
   } acj_width_t;
   localparam acj_width_t WIDTH_RST = ACJ_W24;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_NS = 10;
   localparam int SER_BIT_NS = 100;
   localparam int SER_BIT_CYC = (SER_BIT_NS / CLK_NS < 1) ? 1 : SER_BIT_NS / CLK_NS;

endpackage

`default_nettype wire

// ---- core/acj_pair_if.sv ----
// channel pair stream carrier
`timescale 1ns/1ps
`default_nettype none

interface acj_pair_if;
   logic valid;
   logic ready;
   logic [23:0] data0;
   logic [23:0] data1;
   modport src (output valid, output data0, output data1, input ready);
   modport snk (input valid, input data0, input data1, output ready);
endinterface

`default_nettype wire

// ---- core/acj_justify.sv ----
// clamps and left-justifies one channel result
`timescale 1ns/1ps
`default_nettype none

module acj_justify (
   // raw result
   input wire logic [acj_pkg::WORD_W-1:0] raw,
   input wire logic satPos,
   input wire logic satNeg,
   // shared ratio
   input wire logic [2:0] osrSel,
   // justified word
   output logic [acj_pkg::WORD_W-1:0] word
);
   import acj_pkg::*;

   logic [23:0] clamped;
   logic [23:0] mask;

   always_comb begin
      if (satPos) begin
         clamped = POS_FULL;
      end else if (satNeg) begin
         clamped = NEG_FULL;
      end else begin
         clamped = raw;
      end
      case (osrSel)
         OSR_32: mask = MASK_32;
         OSR_64: mask = MASK_64;
         OSR_128: mask = MASK_128;
         default: mask = MASK_FULL;
      endcase
      word = clamped & mask;
   end

endmodule // acj_justify

`default_nettype wire

// ---- core/acj_pair_buf.sv ----
// small fifo of channel pairs between converter and serial port
`timescale 1ns/1ps
`default_nettype none

module acj_pair_buf #(
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // streams
   acj_pair_if.snk fillPort,
   acj_pair_if.src drainPort,
   // level
   output logic notEmpty
);
   import acj_pkg::*;

   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);

   initial begin
      if (DEPTH < 2) begin
         $error("acj_pair_buf: DEPTH must be at least 2");
      end
   end

   logic [47:0] mem [DEPTH];
   logic [PTR_W-1:0] wrPtr_q;
   logic [PTR_W-1:0] rdPtr_q;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic notFull_q;
   logic push;
   logic pop;

   assign push = fillPort.valid & notFull_q;
   assign pop = drainPort.ready & (cnt_q != '0);
   assign fillPort.ready = notFull_q;
   assign drainPort.valid = (cnt_q != '0);
   assign drainPort.data0 = mem[rdPtr_q][23:0];
   assign drainPort.data1 = mem[rdPtr_q][47:24];
   assign notEmpty = (cnt_q != '0);

   always_comb begin
      cnt_d = cnt_q;
      if (push && !pop) begin
         cnt_d = cnt_q + CNT_W'(1);
      end else if (pop && !push) begin
         cnt_d = cnt_q - CNT_W'(1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wrPtr_q] <= {fillPort.data1, fillPort.data0};
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         cnt_q <= '0;
         notFull_q <= 1'b1;
      end else begin
         if (push) begin
            wrPtr_q <= (wrPtr_q == PTR_W'(DEPTH - 1)) ? '0 : wrPtr_q + PTR_W'(1);
         end
         if (pop) begin
            rdPtr_q <= (rdPtr_q == PTR_W'(DEPTH - 1)) ? '0 : rdPtr_q + PTR_W'(1);
         end
         cnt_q <= cnt_d;
         notFull_q <= (cnt_d < CNT_W'(DEPTH));
      end
   end

endmodule // acj_pair_buf

`default_nettype wire

// ---- sim/acj_checker_properties.sv ----
// port assertions for the output code justifier
`timescale 1ns/1ps
`default_nettype none

module acj_checker #(
   parameter int SER_DIV = acj_pkg::SER_BIT_CYC
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [acj_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // stream and controls
   input wire logic convValid,
   input wire logic convReady,
   input wire logic serFrame,
   input wire logic intRefEnable,
   input wire logic [7:0] refTrim,
   input wire logic [2:0] osrSetting
);
   import acj_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   int frameLen_q;
   logic [7:0] wrTrim;
   logic [2:0] wrOsr;
   logic wrSel;
   assign wrTrim = pwdata[7:0];
   assign wrOsr = pwdata[10:8];
   assign wrSel = pwdata[0];
   // cycles of the current word
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         frameLen_q <= 0;
      end else begin
         frameLen_q <= serFrame ? frameLen_q + 1 : 0;
      end
   end
   sequence accessStart;
      psel && $rose(penable);
   endsequence
   sequence regWrite(a);
      psel && penable && pready && pwrite && paddr == a;
   endsequence
   a_access_two_cycles: assert property (accessStart |-> !pready ##1 pready)
      else $error("access phase length wrong");
   a_ready_one_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_unmapped_error: assert property (pready && paddr > OFF_DATA1 |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_mapped_no_error: assert property (pready && paddr[1:0] == 2'h0 && paddr <= OFF_DATA1 |-> !pslverr)
      else $error("mapped access refused");
   a_trim_osr_write: assert property (regWrite(OFF_CFG0) |=>
      refTrim == $past(wrTrim) && osrSetting == $past(wrOsr)) else $error("first_config_register write lost");
   a_refsel_write: assert property (regWrite(OFF_CFG1) |=>
      intRefEnable == !$past(wrSel)) else $error("reference select wrong");
   a_reset_defaults: assert property ($rose(rst_b) |->
      refTrim == 8'h50 && intRefEnable && osrSetting == 3'h3) else $error("reset value wrong");
   a_word_length: assert property ($fell(serFrame) |->
      frameLen_q inside {16 * SER_DIV, 24 * SER_DIV, 32 * SER_DIV}) else $error("bad word length");
   a_ready_drop_cause: assert property ($fell(convReady) |-> $past(convValid))
      else $error("ready fell without a push");
endmodule // acj_checker

bind adc_output_code_justify acj_checker #(.SER_DIV(SER_DIV)) acj_checker_inst (
   .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .convValid(convValid), .convReady(convReady), .serFrame(serFrame),
   .intRefEnable(intRefEnable), .refTrim(refTrim), .osrSetting(osrSetting));

`default_nettype wire

// ---- sim/acj_host_rx.sv ----
// host side receiver that collects serial words
`timescale 1ns/1ps
`default_nettype none

module acj_host_rx #(
   parameter int SER_DIV = 1
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // serial words
   input wire logic serData,
   input wire logic serFrame,
   input wire logic serChan
);
   logic [31:0] words [64];
   int lens [64];
   logic chans [64];
   int wordCount;
   logic [31:0] shift;
   int len;
   int div;
   // one sample per bit period, msb first
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wordCount = 0;
         len = 0;
         div = 0;
         shift = 32'h0;
      end else if (serFrame) begin
         if (div == 0) begin
            shift = {shift[30:0], serData};
            len++;
            chans[wordCount] = serChan;
         end
         div = (div == SER_DIV - 1) ? 0 : div + 1;
      end else if (len != 0) begin
         words[wordCount] = shift;
         lens[wordCount] = len;
         wordCount++;
         len = 0;
         div = 0;
         shift = 32'h0;
      end
   end
endmodule // acj_host_rx

`default_nettype wire

// ---- sim/tb_adc_output_code_justify.sv ----
// register and stream tests of the output code justifier
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checksDone++; if ((g) !== (e)) begin numErrors++; \
   $display("mismatch %s exp %h got %h", nm, e, g); end end

module tb_adc_output_code_justify;
   import acj_pkg::*;
   localparam int DIV = 1;
   localparam logic [23:0] MSK [5] = '{MASK_32, MASK_64, MASK_128, MASK_FULL, MASK_FULL};
   localparam int FLEN [4] = '{16, 24, 32, 32};
   logic clk_sys, rst_b, psel, penable, pwrite, convValid, pready, pslverr, convReady;
   logic serData, serFrame, serChan, intRefEnable, er, sawFull;
   logic [7:0] paddr, refTrim;
   logic [31:0] pwdata, prdata, rd;
   logic [23:0] convData0, convData1;
   logic [1:0] satPos, satNeg;
   logic [2:0] osrSetting;
   int numErrors, checksDone, seen, i;

   adc_output_code_justify #(.SER_DIV(DIV), .BUF_DEPTH(2)) adc_output_code_justify_inst (
      .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .convValid(convValid), .convData0(convData0), .convData1(convData1), .satPos(satPos),
      .satNeg(satNeg), .convReady(convReady), .serData(serData), .serFrame(serFrame),
      .serChan(serChan), .intRefEnable(intRefEnable), .refTrim(refTrim),
      .osrSetting(osrSetting));
   acj_host_rx #(.SER_DIV(DIV)) acj_host_rx_inst (.clk_sys(clk_sys), .rst_b(rst_b),
      .serData(serData), .serFrame(serFrame), .serChan(serChan));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task wrap_up;
      if (numErrors == 0 && checksDone > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge clk_sys);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin numErrors++; wrap_up(); end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clk_sys);
   endtask

   task push(input logic [23:0] d0, input logic [23:0] d1, input logic [1:0] sp, input logic [1:0] sn);
      int n;
      convValid <= 1'b1; convData0 <= d0; convData1 <= d1; satPos <= sp; satNeg <= sn;
      for (n = 0; n < 200; n++) begin
         @(posedge clk_sys);
         if (convReady === 1'b1) break;
         sawFull = 1'b1;
      end
      if (n == 200) begin numErrors++; wrap_up(); end
   endtask

   task take(input logic [31:0] exp, input int len, input logic ch);
      int n;
      for (n = 0; n < 300 && acj_host_rx_inst.wordCount <= seen; n++) @(posedge clk_sys);
      if (n == 300) begin numErrors++; wrap_up(); end
      `CHK("serial word", exp, acj_host_rx_inst.words[seen])
      `CHK("word length", len, acj_host_rx_inst.lens[seen])
      `CHK("word channel", ch, acj_host_rx_inst.chans[seen])
      seen++;
   endtask

   task pair(input logic [23:0] d0, input logic [23:0] d1, input logic [1:0] sp,
         input logic [1:0] sn, input logic [23:0] e0, input logic [23:0] e1);
      push(d0, d1, sp, sn);
      convValid <= 1'b0;
      take({8'h0, e0}, 24, 1'b0);
      take({8'h0, e1}, 24, 1'b1);
      apb(1'b0, OFF_DATA0, 32'h0);
      `CHK("data0", {8'h0, e0}, rd)
      apb(1'b0, OFF_DATA1, 32'h0);
      `CHK("data1", {8'h0, e1}, rd)
   endtask

   function automatic logic [31:0] fmtWord(input int f, input logic [23:0] w);
      case (f)
         0: return {16'h0, w[23:8]};
         1: return {8'h0, w};
         2: return {w, 8'h0};
         default: return {{8{w[23]}}, w};
      endcase
   endfunction

   initial begin
      rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
      convValid = 1'b0; convData0 = 24'h0; convData1 = 24'h0; satPos = 2'h0; satNeg = 2'h0;
      numErrors = 0; checksDone = 0; seen = 0; sawFull = 1'b0;
      repeat (5) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      `CHK("trim out", 8'h50, refTrim)
      `CHK("int ref", 1'b1, intRefEnable)
      `CHK("osr out", 3'h3, osrSetting)
      apb(1'b0, OFF_CFG0, 32'h0);
      `CHK("first_config_register", 32'h350, rd)
      apb(1'b0, OFF_CFG1, 32'h0);
      `CHK("second_config_register", 32'h0, rd)
      apb(1'b0, OFF_STAT, 32'h0);
      `CHK("format", 2'h1, rd[1:0])
      apb(1'b0, 8'h40, 32'h0);
      `CHK("slverr", 1'b1, er)
      apb(1'b1, 8'h40, 32'h1ff);
      `CHK("slverr write", 1'b1, er)
      `CHK("trim kept", 8'h50, refTrim)
      for (i = 0; i < 5; i++) begin
         apb(1'b1, OFF_CFG0, {21'h0, 3'(i), 8'h50});
         `CHK("osr set", 3'(i), osrSetting)
         pair(24'h0, 24'h8000ff, 2'b01, 2'b00,
            POS_FULL & MSK[i], 24'h8000ff & MSK[i]);
      end
      pair(24'hffffff, 24'hffffff, 2'b00, 2'b10, 24'hffffff, NEG_FULL);
      for (i = 0; i < 4; i++) begin
         apb(1'b1, OFF_STAT, i);
         push(24'h8000ff, 24'h000010, 2'b00, 2'b00);
         convValid <= 1'b0;
         take(fmtWord(i, 24'h8000ff), FLEN[i], 1'b0);
         take(fmtWord(i, 24'h000010), FLEN[i], 1'b1);
      end
      apb(1'b1, OFF_STAT, 32'h1);
      apb(1'b1, OFF_CFG1, 32'h1);
      `CHK("ext ref", 1'b0, intRefEnable)
      apb(1'b0, OFF_CFG1, 32'h0);
      `CHK("second_config_register set", 32'h1, rd)
      apb(1'b1, OFF_CFG1, 32'h0);
      `CHK("int ref back", 1'b1, intRefEnable)
      apb(1'b1, OFF_CFG0, 32'h342);
      `CHK("trim cal", 8'h42, refTrim)
      apb(1'b0, OFF_CFG0, 32'h0);
      `CHK("first_config_register cal", 32'h342, rd)
      sawFull = 1'b0;
      for (i = 0; i < 4; i++) push(24'h100000 + 24'(i), 24'h200000 + 24'(i), 2'b00, 2'b00);
      convValid <= 1'b0;
      `CHK("buffer full", 1'b1, sawFull)
      apb(1'b0, OFF_STAT, 32'h0);
      `CHK("status busy", 32'h301, rd)
      for (i = 0; i < 4; i++) begin
         take({8'h0, 24'h100000 + 24'(i)}, 24, 1'b0);
         take({8'h0, 24'h200000 + 24'(i)}, 24, 1'b1);
      end
      apb(1'b0, OFF_STAT, 32'h0);
      `CHK("status idle", 32'h1, rd)
      rst_b <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      `CHK("trim reset", 8'h50, refTrim)
      `CHK("osr reset", 3'h3, osrSetting)
      `CHK("int ref reset", 1'b1, intRefEnable)
      apb(1'b0, OFF_STAT, 32'h0);
      `CHK("format reset", 32'h1, rd)
      wrap_up();
   end
endmodule // tb_adc_output_code_justify

`default_nettype wire
